// File: design/sers_pkg.sv
package sers_pkg;

   // ****************************************************************
   // Bit positions of the interface event latch.
   // ****************************************************************
   localparam int unsigned IE_OPS_DONE_BIT = 0;
   localparam int unsigned IE_QUERY_ERR_BIT = 2;
   localparam int unsigned IE_EXEC_ERR_BIT = 4;
   localparam int unsigned IE_CMD_ERR_BIT = 5;
   localparam int unsigned IE_POWER_ON_BIT = 7;
   localparam logic [7:0] IE_USED_MASK = 8'hb5;

   // ****************************************************************
   // Bit positions of the operation event latch and status byte.
   // ****************************************************************
   localparam int unsigned OP_ALARM_BIT = 0;
   localparam int unsigned OP_OVERLOAD_BIT = 1;
   localparam int unsigned OP_LOOP_TWO_RAMP_BIT = 2;
   localparam int unsigned OP_LOOP_ONE_RAMP_BIT = 3;
   localparam int unsigned OP_NEW_READING_BIT = 4;
   localparam int unsigned OP_AUTOTUNE_DONE_BIT = 5;
   localparam int unsigned OP_CAL_BIT = 6;
   localparam int unsigned OP_COM_BIT = 7;
   localparam int unsigned SB_ESB_BIT = 5;
   localparam int unsigned SB_OSB_BIT = 7;

   // ****************************************************************
   // Reset values and decimal answer width.
   // ****************************************************************
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam int unsigned DEC_DIGITS = 3;

   // ****************************************************************
   // Query and command codes on the command port.
   // ****************************************************************
   typedef enum logic [3:0] {
      SERS_CMD_NONE,
      SERS_CMD_CLEAR_STATUS,
      SERS_CMD_IE_ENABLE_WRITE,
      SERS_CMD_IE_ENABLE_READ,
      SERS_CMD_IE_EVENT_READ,
      SERS_CMD_OP_ENABLE_WRITE,
      SERS_CMD_OP_ENABLE_READ,
      SERS_CMD_OP_EVENT_READ,
      SERS_CMD_OP_COND_READ,
      SERS_CMD_SR_ENABLE_WRITE,
      SERS_CMD_SR_ENABLE_READ,
      SERS_CMD_STATUS_BYTE_READ,
      SERS_CMD_COMPLETION_ARM
   } sers_cmd_e;

   typedef struct packed {
      logic valid;
      sers_cmd_e code;
      logic [7:0] value;
   } sers_cmd_s;

   typedef struct packed {
      logic valid;
      logic [7:0] value;
      logic [3:0] hundreds;
      logic [3:0] tens;
      logic [3:0] ones;
   } sers_rsp_s;

   typedef struct packed {
      logic power_on;
      logic command_error;
      logic execution_error;
      logic query_error;
      logic ops_done;
   } sers_ie_evt_s;

   typedef struct packed {
      logic comm_error;
      logic cal_error;
      logic autotune_active;
      logic new_reading;
      logic loop_one_ramp_done;
      logic loop_two_ramp_done;
      logic overload;
      logic alarm;
      logic alarm_visible;
   } sers_op_cond_s;

endpackage

// File: design/sers_dec8.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Binary to three decimal digits, registered.
// ****************************************************************
module sers_dec8
   import sers_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire logic [7:0] bin,
   output logic [3:0] hundreds,
   output logic [3:0] tens,
   output logic [3:0] ones
);

   typedef struct packed {
      logic [3:0] h;
      logic [3:0] t;
      logic [3:0] o;
   } sers_dec_s;

   sers_dec_s st_r;
   sers_dec_s st_nxt;

   always_comb begin
      logic [7:0] rem;
      rem = bin;
      st_nxt = '0;
      st_nxt.h = 4'(rem / 8'd100);
      rem = 8'(rem % 8'd100);
      st_nxt.t = 4'(rem / 8'd10);
      st_nxt.o = 4'(rem % 8'd10);
      if (!nrst) begin
         st_nxt = '0;
      end
   end

   always_ff @(posedge mclk) begin
      st_r <= st_nxt;
   end

   assign hundreds = st_r.h;
   assign tens = st_r.t;
   assign ones = st_r.o;

endmodule
`default_nettype wire

// File: design/sers_status.sv
// Behaviour
// - Query answers binary weighted decimal sum.
// - Only enable registers are writable.
// - Interface event read returns then clears.
// - Clear-status and power-on clear both events.
// - Zero write or power-on clears enables.
// - Summary bits follow event registers, no clear.
// - Interface summary is OR of enabled events.
// - Operation summary is OR of enabled events.
// - Power-on sets interface bit 7.
// - Command error sets bit 5.
// - Execution error sets bit 4.
// - Lost response data sets bit 2.
// - Armed completion sets bit 0.
// - Processor comm error sets operation bit 7.
// - Calibration error sets operation bit 6.
// - Autotune idle sets operation bit 5.
// - New reading sets operation bit 4.
// - Ramp done sets bits 3 and 2.
// - Sensor overload sets operation bit 1.
// - Alarm with visibility sets bit 0.
// - Event read clears; condition read does not.
// - Event bits latch until cleared.
// - Condition register is live, read-only.
`timescale 1ns/1ps
`default_nettype none

module sers_status
   import sers_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire sers_cmd_s cmd,
   input wire sers_ie_evt_s ie_evt,
   input wire sers_op_cond_s op_cond,
   output sers_rsp_s rsp,
   output logic [7:0] status_byte,
   output logic [7:0] op_condition,
   output logic completion_armed
);

   // ****************************************************************
   // State.
   // ****************************************************************
   typedef struct packed {
      logic [7:0] ie_event;
      logic [7:0] ie_enable;
      logic [7:0] op_event;
      logic [7:0] op_enable;
      logic [7:0] sr_enable;
      logic [7:0] op_cond;
      logic [7:0] sbyte;
      logic completion_arm;
      logic power_seen;
      logic rsp_pend;
      logic rsp_valid;
      logic [7:0] rsp_value;
      logic [7:0] rsp_shown;
   } sers_state_s;

   sers_state_s st_r;
   sers_state_s st_nxt;
   logic [3:0] dec_h;
   logic [3:0] dec_t;
   logic [3:0] dec_o;
   logic [7:0] ie_set;
   logic [7:0] op_live;

   // ****************************************************************
   // Event sources.
   // ****************************************************************
   always_comb begin
      ie_set = '0;
      ie_set[IE_POWER_ON_BIT] = !st_r.power_seen;
      ie_set[IE_CMD_ERR_BIT] = ie_evt.command_error;
      ie_set[IE_EXEC_ERR_BIT] = ie_evt.execution_error;
      ie_set[IE_QUERY_ERR_BIT] = ie_evt.query_error;
      ie_set[IE_OPS_DONE_BIT] = st_r.completion_arm && ie_evt.ops_done;
      ie_set = ie_set & IE_USED_MASK;
      op_live = '0;
      op_live[OP_COM_BIT] = op_cond.comm_error;
      op_live[OP_CAL_BIT] = op_cond.cal_error;
      op_live[OP_AUTOTUNE_DONE_BIT] = !op_cond.autotune_active;
      op_live[OP_NEW_READING_BIT] = op_cond.new_reading;
      op_live[OP_LOOP_ONE_RAMP_BIT] = op_cond.loop_one_ramp_done;
      op_live[OP_LOOP_TWO_RAMP_BIT] = op_cond.loop_two_ramp_done;
      op_live[OP_OVERLOAD_BIT] = op_cond.overload;
      op_live[OP_ALARM_BIT] = op_cond.alarm && op_cond.alarm_visible;
   end

   // ****************************************************************
   // Next state.
   // ****************************************************************
   always_comb begin
      logic [7:0] ie_ev;
      logic [7:0] op_ev;
      ie_ev = st_r.ie_event;
      op_ev = st_r.op_event;
      st_nxt = st_r;
      st_nxt.rsp_valid = 1'b0;
      st_nxt.rsp_pend = 1'b0;
      st_nxt.power_seen = 1'b1;
      st_nxt.op_cond = op_live;
      // The binary value trails by one so that it stands beside the digits of the same answer.
      st_nxt.rsp_shown = st_r.rsp_value;
      // Completion disarms before commands are decoded, so a fresh arm on that cycle wins.
      if (ie_set[IE_OPS_DONE_BIT]) begin
         st_nxt.completion_arm = 1'b0;
      end
      if (cmd.valid) begin
         st_nxt.rsp_pend = 1'b1;
         case (cmd.code)
            SERS_CMD_CLEAR_STATUS: begin
               ie_ev = '0;
               op_ev = '0;
               st_nxt.rsp_pend = 1'b0;
            end
            SERS_CMD_IE_ENABLE_WRITE: begin
               st_nxt.ie_enable = cmd.value & IE_USED_MASK;
               st_nxt.rsp_pend = 1'b0;
            end
            SERS_CMD_OP_ENABLE_WRITE: begin
               st_nxt.op_enable = cmd.value;
               st_nxt.rsp_pend = 1'b0;
            end
            SERS_CMD_SR_ENABLE_WRITE: begin
               st_nxt.sr_enable = cmd.value;
               st_nxt.rsp_pend = 1'b0;
            end
            SERS_CMD_IE_ENABLE_READ: st_nxt.rsp_value = st_r.ie_enable;
            SERS_CMD_OP_ENABLE_READ: st_nxt.rsp_value = st_r.op_enable;
            SERS_CMD_SR_ENABLE_READ: st_nxt.rsp_value = st_r.sr_enable;
            SERS_CMD_IE_EVENT_READ: begin
               st_nxt.rsp_value = st_r.ie_event;
               ie_ev = '0;
            end
            SERS_CMD_OP_EVENT_READ: begin
               st_nxt.rsp_value = st_r.op_event;
               op_ev = '0;
            end
            SERS_CMD_OP_COND_READ: st_nxt.rsp_value = st_r.op_cond;
            SERS_CMD_STATUS_BYTE_READ: st_nxt.rsp_value = st_r.sbyte;
            SERS_CMD_COMPLETION_ARM: begin
               st_nxt.completion_arm = 1'b1;
               st_nxt.rsp_pend = 1'b0;
            end
            default: st_nxt.rsp_pend = 1'b0;
         endcase
      end
      // Sets are applied after clears so an event on the clearing cycle survives.
      st_nxt.ie_event = ie_ev | ie_set;
      st_nxt.op_event = op_ev | op_live;
      st_nxt.sbyte = '0;
      st_nxt.sbyte[SB_ESB_BIT] = |(st_nxt.ie_event & st_nxt.ie_enable);
      st_nxt.sbyte[SB_OSB_BIT] = |(st_nxt.op_event & st_nxt.op_enable);
      // The decimal converter adds one cycle, so the answer strobe trails by one.
      st_nxt.rsp_valid = st_r.rsp_pend;
      if (!nrst) begin
         st_nxt = '0;
         st_nxt.ie_enable = REG_RESET;
         st_nxt.op_enable = REG_RESET;
         st_nxt.sr_enable = REG_RESET;
      end
   end

   always_ff @(posedge mclk) begin
      st_r <= st_nxt;
   end

   // ****************************************************************
   // Decimal answer.
   // ****************************************************************
   sers_dec8 u_dec (
      .mclk(mclk),
      .nrst(nrst),
      .bin(st_r.rsp_value),
      .hundreds(dec_h),
      .tens(dec_t),
      .ones(dec_o)
   );

   always_comb begin
      rsp = '0;
      rsp.valid = st_r.rsp_valid;
      rsp.value = st_r.rsp_shown;
      rsp.hundreds = dec_h;
      rsp.tens = dec_t;
      rsp.ones = dec_o;
   end

   assign status_byte = st_r.sbyte;
   assign op_condition = st_r.op_cond;
   assign completion_armed = st_r.completion_arm;

endmodule
`default_nettype wire

// File: verification/sers_status_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sers_status_asserts
   import sers_pkg::*;
(
   input wire logic mclk,
   input wire logic nrst,
   input wire sers_cmd_s cmd,
   input wire sers_ie_evt_s ie_evt,
   input wire sers_op_cond_s op_cond,
   input wire sers_rsp_s rsp,
   input wire logic [7:0] status_byte,
   input wire logic [7:0] op_condition,
   input wire logic completion_armed
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!nrst);
   logic rd_c;
   logic quiet;
   logic [7:0] cv;
   assign rd_c = cmd.valid && (cmd.code inside {SERS_CMD_IE_ENABLE_READ,
      SERS_CMD_IE_EVENT_READ, SERS_CMD_OP_ENABLE_READ, SERS_CMD_OP_EVENT_READ,
      SERS_CMD_OP_COND_READ, SERS_CMD_SR_ENABLE_READ, SERS_CMD_STATUS_BYTE_READ});
   assign quiet = ie_evt[3:0] == 4'h0;
   assign cv = {op_cond.comm_error, op_cond.cal_error, !op_cond.autotune_active,
      op_cond.new_reading, op_cond.loop_one_ramp_done, op_cond.loop_two_ramp_done,
      op_cond.overload,
      op_cond.alarm && op_cond.alarm_visible};
   property p_rsp_lat; rd_c |-> ##2 rsp.valid; endproperty
   a_rsp_lat: assert property (p_rsp_lat) else $error("read not answered");
   property p_wr_quiet; cmd.valid && !rd_c |-> ##2 !rsp.valid; endproperty
   a_wr_quiet: assert property (p_wr_quiet) else $error("write answered");
   property p_bcd;
      rsp.valid |-> 12'(rsp.hundreds) * 12'd100 + 12'(rsp.tens) * 12'd10
         + 12'(rsp.ones) == 12'(rsp.value);
   endproperty
   a_bcd: assert property (p_bcd) else $error("decimal answer wrong");
   property p_cond; $past(nrst) |-> op_condition == $past(cv); endproperty
   a_cond: assert property (p_cond) else $error("condition not live");
   property p_esb_rd;
      $past(nrst) && quiet && cmd.valid && cmd.code == SERS_CMD_IE_EVENT_READ
         |=> !status_byte[SB_ESB_BIT];
   endproperty
   a_esb_rd: assert property (p_esb_rd) else $error("summary kept");
   property p_cls;
      $past(nrst) && quiet && cv == 8'h00 && $past(cv) == 8'h00 && cmd.valid
         && cmd.code == SERS_CMD_CLEAR_STATUS |=> status_byte == 8'h00;
   endproperty
   a_cls: assert property (p_cls) else $error("clear left bits");
   property p_sb_unused; (status_byte & 8'h5f) == 8'h00; endproperty
   a_sb_unused: assert property (p_sb_unused) else $error("stray status bit");
   property p_arm_kept;
      cmd.valid && cmd.code == SERS_CMD_COMPLETION_ARM |=> completion_armed;
   endproperty
   a_arm_kept: assert property (p_arm_kept) else $error("arm lost");
   c_power_up: cover property (rsp.valid && rsp.value == 8'h80);
   c_esb: cover property (status_byte[SB_ESB_BIT]);
   c_osb: cover property (status_byte[SB_OSB_BIT]);
endmodule
bind sers_status sers_status_asserts u_chk (.mclk, .nrst, .cmd, .ie_evt, .op_cond,
   .rsp, .status_byte, .op_condition, .completion_armed);
`default_nettype wire

// File: verification/sers_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none
module sers_ctl_model
   import sers_pkg::*;
(
   input wire logic mclk,
   output var sers_cmd_s cmd,
   input wire sers_rsp_s rsp
);
   initial cmd = '0;
   task automatic wr(input sers_cmd_e c, input logic [7:0] v);
      @(negedge mclk);
      cmd = '{1'b1, c, v};
      @(negedge mclk);
      cmd = '0;
   endtask
   task automatic rd(input sers_cmd_e c, output logic [20:0] r);
      @(negedge mclk);
      cmd = '{1'b1, c, 8'h00};
      @(negedge mclk);
      cmd = '0;
      @(negedge mclk);
      r = {rsp.valid, rsp.value, rsp.hundreds, rsp.tens, rsp.ones};
   endtask
endmodule
`default_nettype wire

// File: verification/sers_status_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sers_status_tb
   import sers_pkg::*;
;
   logic mclk = 0;
   logic nrst = 0;
   sers_cmd_s cmd;
   sers_ie_evt_s ie_evt = '0;
   sers_op_cond_s op_cond = 9'h040;
   sers_rsp_s rsp;
   logic [7:0] status_byte;
   logic [7:0] op_condition;
   logic completion_armed;
   int err_count = 0;
   int checks = 0;
   logic [20:0] r;
   always #2.5 mclk = ~mclk;
   sers_status DUT (.mclk, .nrst, .cmd, .ie_evt, .op_cond, .rsp, .status_byte,
      .op_condition, .completion_armed);
   sers_ctl_model CTL (.mclk, .cmd, .rsp);
   task automatic chk(input logic [20:0] g, input logic [20:0] e);
      checks++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   function automatic logic [20:0] ex(input logic [7:0] v);
      return {1'b1, v, 4'(v / 100), 4'(v / 10 % 10), 4'(v % 10)};
   endfunction
   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask
   task automatic evt(input logic [4:0] e);
      tick(1);
      ie_evt = e;
      tick(1);
      ie_evt = '0;
   endtask
   task automatic t_pon;
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h80));
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h00));
   endtask
   task automatic t_ie;
      evt(5'h0e);
      evt(5'h08);
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h34));
   endtask
   task automatic t_done;
      evt(5'h01);
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h00));
      CTL.wr(SERS_CMD_COMPLETION_ARM, 8'h00);
      chk(21'(completion_armed), 21'h1);
      evt(5'h01);
      chk(21'(completion_armed), 21'h0);
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h01));
   endtask
   task automatic t_en;
      CTL.wr(SERS_CMD_IE_ENABLE_WRITE, 8'h20);
      CTL.rd(SERS_CMD_IE_ENABLE_READ, r);
      chk(r, ex(8'h20));
      evt(5'h08);
      tick(2);
      chk(21'(status_byte), 21'h20);
      CTL.rd(SERS_CMD_STATUS_BYTE_READ, r);
      chk(r, ex(8'h20));
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h20));
      chk(21'(status_byte), 21'h00);
      CTL.wr(SERS_CMD_IE_ENABLE_WRITE, 8'h00);
      CTL.rd(SERS_CMD_IE_ENABLE_READ, r);
      chk(r, ex(8'h00));
      CTL.wr(SERS_CMD_IE_ENABLE_WRITE, 8'hff);
      CTL.rd(SERS_CMD_IE_ENABLE_READ, r);
      chk(r, ex(8'hb5));
   endtask
   task automatic t_op;
      op_cond = 9'h1bf;
      tick(2);
      chk(21'(op_condition), 21'hff);
      CTL.wr(SERS_CMD_OP_ENABLE_WRITE, 8'h80);
      tick(1);
      chk(21'(status_byte), 21'h80);
      op_cond = 9'h042;
      tick(1);
      CTL.rd(SERS_CMD_OP_COND_READ, r);
      chk(r, ex(8'h00));
      CTL.rd(SERS_CMD_OP_EVENT_READ, r);
      chk(r, ex(8'hff));
      CTL.rd(SERS_CMD_OP_EVENT_READ, r);
      chk(r, ex(8'h00));
      CTL.rd(SERS_CMD_OP_ENABLE_READ, r);
      chk(r, ex(8'h80));
   endtask
   task automatic t_cls;
      op_cond = 9'h140;
      evt(5'h08);
      op_cond = 9'h040;
      tick(1);
      chk(21'(status_byte), 21'ha0);
      CTL.wr(SERS_CMD_CLEAR_STATUS, 8'h00);
      tick(1);
      chk(21'(status_byte), 21'h00);
      CTL.rd(SERS_CMD_OP_EVENT_READ, r);
      chk(r, ex(8'h00));
      CTL.wr(SERS_CMD_SR_ENABLE_WRITE, 8'ha0);
      CTL.rd(SERS_CMD_SR_ENABLE_READ, r);
      chk(r, ex(8'ha0));
   endtask
   task automatic t_rst;
      op_cond = 9'h140;
      evt(5'h08);
      op_cond = 9'h040;
      tick(1);
      chk(21'(status_byte), 21'ha0);
      nrst = 0;
      tick(3);
      nrst = 1;
      chk(21'(status_byte), 21'h00);
      CTL.rd(SERS_CMD_IE_ENABLE_READ, r);
      chk(r, ex(8'h00));
      CTL.rd(SERS_CMD_OP_ENABLE_READ, r);
      chk(r, ex(8'h00));
      CTL.rd(SERS_CMD_SR_ENABLE_READ, r);
      chk(r, ex(8'h00));
      CTL.rd(SERS_CMD_IE_EVENT_READ, r);
      chk(r, ex(8'h80));
      CTL.rd(SERS_CMD_OP_EVENT_READ, r);
      chk(r, ex(8'h00));
   endtask
   task automatic complete_run;
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge mclk);
      nrst = 1;
      t_pon;
      t_ie;
      t_done;
      t_en;
      t_op;
      t_cls;
      t_rst;
      complete_run;
   end
   // The sequence needs well under a thousand cycles, so a hang shows long before this.
   initial begin
      #20000;
      err_count++;
      complete_run;
   end
endmodule
`default_nettype wire
